// ==== rtl/trng_pkg.sv ====
// Purpose: Shared constants and types for the true random byte generator.
// Assumes: Avalon-MM register bus, 32-bit data, byte addressing.
// Notes:   Timing counts derive from the 125 MHz clock.
package trng_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFF_START   = 12'h000;
  localparam logic [11:0] OFF_STOP    = 12'h004;
  localparam logic [11:0] OFF_VALUE_READY = 12'h100;
  localparam logic [11:0] OFF_SHORTCUT    = 12'h200;
  localparam logic [11:0] OFF_IENSET  = 12'h304;
  localparam logic [11:0] OFF_IENCLR  = 12'h308;
  localparam logic [11:0] OFF_CONFIG  = 12'h504;
  localparam logic [11:0] OFF_VALUE   = 12'h508;
  localparam logic [11:0] OFF_STATUS  = 12'h50c;

  // Field positions and reset values.
  localparam int          BIT_TRIG    = 0;
  localparam int          BIT_BIAS    = 0;
  localparam int          BIT_SHORT   = 0;
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // Timing, in the printed units, and derived cycle counts.
  localparam int CLK_MHZ     = 125;
  localparam int T_START_US  = 128;
  localparam int T_RAW_US    = 30;
  localparam int T_BC_US     = 120;
  localparam int START_CYC   = T_START_US * CLK_MHZ;
  localparam int RAW_BIT_CYC = (T_RAW_US * CLK_MHZ) / 8;
  localparam int BC_BIT_CYC  = (T_BC_US * CLK_MHZ) / 8 / 4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WARMUP,
    ST_RUN
  } trng_state_e;

  // Avalon-MM slave request bundle.
  typedef struct packed {
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } trng_req_s;

endpackage

// ==== rtl/trng_core.sv ====
// Purpose: True random byte generator with Avalon-MM registers and interrupt.
// Assumes: noise_i is an asynchronous raw noise bit stream; one 125 MHz clock.
// Notes:   Registers answer one cycle after the request is seen.
// Functional notes
// - Writing the start trigger begins production and writing the stop trigger ends it.
// - While running, bytes are produced back to back with no pause between them.
// - Each byte loaded into the output register raises the value-ready event once.
// - Each new byte overwrites the output register, so software must read it in time.
// - Corrected or raw bits shift into an 8-bit holding register and load in parallel.
// - With bias correction enabled, bit pairs are debiased so ones and zeros are uniform.
// - The byte interval is fixed without bias correction and varies only when bias correction is on.
// - No seed input or seed register is needed.
// - The start trigger sits at 0x000 and the stop trigger at 0x004.
// - The value-ready flag sits at 0x100 and is set on every new output byte.
// - Writing one to bit 0 at 0x304 enables the interrupt; reads show the enable.
// - The first byte after start follows a one-time start-up delay of 128 us.
// - Without correction a byte takes about 30 us.
// - With correction a byte takes about 120 us and has no upper bound.
module trng_core
  import trng_pkg::*;
#(
  parameter int START_CYCLES = START_CYC
) (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Avalon-MM slave.
  input  wire trng_pkg::trng_req_s avs_req_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Noise source, interrupt and run status.
  input  wire logic        noise_i,
  output logic             irq_o,
  output logic             running_o
);
  import trng_pkg::*;

  logic              noise_s1_q, noise_s2_q;
  trng_state_e       state_q;
  logic [31:0]       wait_q;
  logic [15:0]       bit_cnt_q;
  logic [2:0]        nbits_q;
  logic [7:0]        shift_q;
  logic [7:0]        value_q;
  logic              flag_q, ien_q, bias_q, short_q;
  logic              pair_have_q, pair_first_q;
  logic              ack_q;
  logic [31:0]       rdata_q;

  // Bus decode; the answer comes one cycle after the request.
  wire       req_any   = (avs_req_i.read | avs_req_i.write) & ~ack_q;
  // A write lands at the edge at which the master samples waitrequest low,
  // which is the one edge that ack_q is high, so it acts exactly once.
  wire       wr_en     = avs_req_i.write & ack_q & avs_req_i.byteenable[0];
  wire [0:0] wd0       = avs_req_i.writedata[0];
  wire       wr_start  = wr_en & (avs_req_i.address == OFF_START) & wd0[0];
  wire       wr_stop   = wr_en & (avs_req_i.address == OFF_STOP) & wd0[0];
  wire       wr_flag   = wr_en & (avs_req_i.address == OFF_VALUE_READY);
  wire       wr_ienset = wr_en & (avs_req_i.address == OFF_IENSET) & wd0[0];
  wire       wr_ienclr = wr_en & (avs_req_i.address == OFF_IENCLR) & wd0[0];
  wire       wr_cfg    = wr_en & (avs_req_i.address == OFF_CONFIG);
  wire       wr_short  = wr_en & (avs_req_i.address == OFF_SHORTCUT);

  assign avs_waitrequest_o = ~ack_q;

  // no seed needed
  // The noise pin is the only entropy; nothing is loaded by software first.
  // Noise pin synchroniser; second stage alone is used.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      noise_s1_q <= 1'b0;
      noise_s2_q <= 1'b0;
    end else begin
      noise_s1_q <= noise_i;
      noise_s2_q <= noise_s1_q;
    end
  end

  // Bit sampling tick: one noise bit is sampled per period while running.
  // raw bit rate
  // corrected bit rate
  // Dropped equal pairs make the corrected byte time open-ended by nature.
  wire [15:0] bit_period = bias_q ? 16'(BC_BIT_CYC) : 16'(RAW_BIT_CYC);
  wire        bit_tick   = (state_q == ST_RUN) && (bit_cnt_q == bit_period - 16'd1);

  // pair debias
  // Pairs 01/10 give one bit, 00/11 are dropped, so the byte time is open-ended.
  wire pair_ok   = pair_have_q & (pair_first_q != noise_s2_q);
  wire bit_take  = bit_tick & (bias_q ? pair_ok : 1'b1);
  wire bit_val   = bias_q ? pair_first_q : noise_s2_q;
  wire byte_done = bit_take & (nbits_q == 3'd7);

  // Run control with one-time warm-up delay.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      wait_q  <= RST_ZERO;
    end else begin
      case (state_q)
        ST_IDLE: if (wr_start) begin
          state_q <= ST_WARMUP;
          wait_q  <= RST_ZERO;
        end
        ST_WARMUP: begin
          wait_q <= wait_q + 32'd1;
          if (wr_stop) begin
            state_q <= ST_IDLE;
          end else if (wait_q == 32'(START_CYCLES - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: if (wr_stop | (short_q & byte_done)) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Bit period counter and pair tracking.
  // variable interval
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt_q    <= 16'h0;
      pair_have_q  <= 1'b0;
      pair_first_q <= 1'b0;
    end else if (state_q != ST_RUN) begin
      bit_cnt_q    <= 16'h0;
      pair_have_q  <= 1'b0;
    end else begin
      bit_cnt_q <= bit_tick ? 16'h0 : bit_cnt_q + 16'd1;
      if (bit_tick) begin
        pair_have_q  <= ~pair_have_q;
        pair_first_q <= noise_s2_q;
      end
    end
  end

  // shift register
  // Partial bytes are discarded on stop so each byte comes from one run.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_q <= 8'h00;
      nbits_q <= 3'd0;
    end else if (state_q != ST_RUN) begin
      nbits_q <= 3'd0;
    end else if (bit_take) begin
      shift_q <= {shift_q[6:0], bit_val};
      nbits_q <= nbits_q + 3'd1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      value_q <= 8'h00;
    end else if (byte_done) begin
      value_q <= {shift_q[6:0], bit_val};
    end
  end

  // one event per byte
  // A new byte in the same cycle as a clear keeps the flag set.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_q <= 1'b0;
    end else if (byte_done) begin
      flag_q <= 1'b1;
    end else if (wr_flag) begin
      flag_q <= wd0[0];
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ien_q   <= 1'b0;
      bias_q  <= 1'b0;
      short_q <= 1'b0;
    end else begin
      if (wr_ienset) begin
        ien_q <= 1'b1;
      end else if (wr_ienclr) begin
        ien_q <= 1'b0;
      end
      if (wr_cfg) begin
        bias_q <= avs_req_i.writedata[BIT_BIAS];
      end
      if (wr_short) begin
        short_q <= avs_req_i.writedata[BIT_SHORT];
      end
    end
  end

  // Read mux; task registers and unmapped addresses read as zero.
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_req_i.address)
      OFF_VALUE_READY: rd_mux = {31'h0, flag_q};
      OFF_SHORTCUT:    rd_mux = {31'h0, short_q};
      OFF_IENSET: rd_mux = {31'h0, ien_q};
      OFF_IENCLR: rd_mux = {31'h0, ien_q};
      OFF_CONFIG: rd_mux = {31'h0, bias_q};
      OFF_VALUE:  rd_mux = {24'h0, value_q};
      OFF_STATUS: rd_mux = {30'h0, state_q == ST_RUN, state_q != ST_IDLE};
      default:    rd_mux = UNMAPPED_RD;
    endcase
  end

  // Bus answer register.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q   <= 1'b0;
      rdata_q <= RST_ZERO;
    end else begin
      ack_q   <= req_any;
      rdata_q <= (req_any & avs_req_i.read) ? rd_mux : rdata_q;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign irq_o          = flag_q & ien_q;
  assign running_o      = (state_q == ST_RUN);

  // Assertions.
  a_irq_level: assert property (@(posedge mclk_i) disable iff (reset_i)
    irq_o == (flag_q && ien_q)) else $error("irq level mismatch");
  a_byte_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
    byte_done |=> flag_q) else $error("flag not set after byte");
  a_byte_value: assert property (@(posedge mclk_i) disable iff (reset_i)
    byte_done |=> value_q == $past({shift_q[6:0], bit_val})) else $error("value not loaded");
  a_start_warm: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_q == ST_IDLE && wr_start) |=> state_q == ST_WARMUP) else $error("start ignored");
  a_stop_idle: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_q != ST_IDLE && wr_stop) |=> state_q == ST_IDLE) else $error("stop ignored");
  a_warm_nobyte: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_WARMUP |-> !byte_done) else $error("byte during warm-up");
  a_ien_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_ienset |=> ien_q) else $error("enable set failed");
  a_ien_clr: assert property (@(posedge mclk_i) disable iff (reset_i)
    (wr_ienclr && !wr_ienset) |=> !ien_q) else $error("enable clear failed");
  a_raw_bits: assert property (@(posedge mclk_i) disable iff (reset_i)
    (bit_tick && !bias_q) |-> bit_take) else $error("raw bit dropped");
  a_bus_ack: assert property (@(posedge mclk_i) disable iff (reset_i)
    req_any |=> !avs_waitrequest_o) else $error("bus answer late");


  // Production only while running, one event per byte.
  a_idle_nobyte: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q != ST_RUN |-> !byte_done) else $error("byte while not running");

  a_one_event: assert property (@(posedge mclk_i) disable iff (reset_i)
    byte_done |=> !byte_done) else $error("two events for one byte");

  // The output register only moves when a byte is complete.
  a_value_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    !byte_done |=> $stable(value_q)) else $error("value changed without byte");

  // Serial bits enter at the bottom of the holding register.
  a_shift_bit: assert property (@(posedge mclk_i) disable iff (reset_i)
    bit_take |=> shift_q[0] == $past(bit_val)) else $error("bit not shifted in");

  a_nbits_reset: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q != ST_RUN |=> nbits_q == 3'd0) else $error("partial byte kept");

  a_read_value: assert property (@(posedge mclk_i) disable iff (reset_i)
    (req_any && avs_req_i.read && avs_req_i.address == OFF_VALUE)
      |=> avs_readdata_o == {24'h0, $past(value_q)}) else $error("value read wrong");

  // Equal pairs must never reach the holding register.
  a_bias_drop: assert property (@(posedge mclk_i) disable iff (reset_i)
    (bit_tick && bias_q && !pair_ok) |-> !bit_take) else $error("equal pair used");

  a_pair_reset: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q != ST_RUN |=> !pair_have_q) else $error("pair state kept");

  a_tick_gap: assert property (@(posedge mclk_i) disable iff (reset_i)
    bit_tick |=> !bit_tick) else $error("bit ticks back to back");

  // Warm-up ends exactly once its count has run out.
  a_warm_exit: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_q == ST_WARMUP && !wr_stop && wait_q == 32'(START_CYCLES - 1))
      |=> state_q == ST_RUN) else $error("warm-up overran");

  a_warm_len: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_q == ST_RUN && $past(state_q) == ST_WARMUP)
      |-> wait_q == 32'(START_CYCLES)) else $error("warm-up too short");

  // A clear with no new byte drops the flag and so the interrupt.
  a_flag_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    (wr_flag && !wd0[0] && !byte_done) |=> !flag_q) else $error("flag not cleared");

  a_ien_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!wr_ienset && !wr_ienclr) |=> $stable(ien_q)) else $error("enable moved");

  a_rdata_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    !(req_any && avs_req_i.read) |=> $stable(avs_readdata_o)) else $error("read data moved");

  // The shortcut stops the run right after the byte it waited for.
  a_short_stop: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_q == ST_RUN && short_q && byte_done) |=> state_q == ST_IDLE)
    else $error("shortcut stop missed");

  // Main scenarios worth seeing at least once.
  c_byte_out:  cover property (@(posedge mclk_i) disable iff (reset_i) byte_done);
  c_warm_stop: cover property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_WARMUP && wr_stop);
  c_irq_rise:  cover property (@(posedge mclk_i) disable iff (reset_i) $rose(irq_o));
  c_bias_byte: cover property (@(posedge mclk_i) disable iff (reset_i) byte_done && bias_q);
  c_set_clear: cover property (@(posedge mclk_i) disable iff (reset_i) byte_done && wr_flag);

endmodule

// ==== dv/trng_core_bench.sv ====
// Purpose: Self-checking bench for the true random byte generator.
// Assumes: Register answers come one cycle after a request is seen.
// Notes:   A short warm-up parameter keeps the run brief.
module trng_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import trng_pkg::*;

  localparam int WARM = 20;
  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  trng_req_s   req      = '0;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [31:0] d;
  logic        waitreq;
  logic        noise    = 1'b0;
  logic        irq;
  logic        running;
  logic        use_rand = 1'b0;
  logic        level    = 1'b0;
  logic [15:0] lfsr     = 16'h004f;
  int          fail_count = 0;
  int          n_tests    = 0;

  // Clock at 125 MHz.
  always #4 mclk = ~mclk;

  trng_core #(.START_CYCLES(WARM)) trng_core_i (
    .mclk_i            (mclk),
    .reset_i           (rst),
    .avs_req_i         (req),
    .avs_readdata_o    (rdata),
    .avs_waitrequest_o (waitreq),
    .noise_i           (noise),
    .irq_o             (irq),
    .running_o         (running)
  );

  // Random source of the bench, seeded at 79 so every run repeats.
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected word holding one flag in bit 0.
  function automatic logic [31:0] exp_bit(input logic b);
    return {31'h0, b};
  endfunction

  // Expected output word when every raw sample of a byte was b.
  function automatic logic [31:0] exp_byte(input logic b);
    return {24'h0, {8{b}}};
  endfunction

  // Noise is a held level or a fresh random bit each cycle.
  always @(posedge mclk) begin
    lfsr  <= lfsr_next(lfsr);
    noise <= use_rand ? lfsr[0] : level;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One bus access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v,
                     input logic [3:0] be);
    @(posedge mclk);
    req.address    <= a;
    req.write      <= w;
    req.read       <= ~w;
    req.writedata  <= v;
    req.byteenable <= be;
    do begin
      @(posedge mclk);
    end while (waitreq !== 1'b0);
    rd = rdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 4'hf);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rd, exp);
  endtask

  // Waits a bounded time for the interrupt, then checks that it came.
  task automatic wait_irq(input int max);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < max) begin
      @(posedge mclk);
      n++;
    end
    check(exp_bit(irq), exp_bit(1'b1));
  endtask

  // Main sequence.
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdc(OFF_IENSET, RST_ZERO);
    rdc(OFF_CONFIG, RST_ZERO);
    rdc(12'h7f0, UNMAPPED_RD);
    check(exp_bit(irq | running), exp_bit(1'b0));
    for (int i = 0; i < 6; i++) begin
      d = {lfsr, lfsr_next(lfsr)};
      bus(1'b1, OFF_CONFIG, d, 4'hf);
      bus(1'b1, OFF_CONFIG, ~d, 4'he);
      rdc(OFF_CONFIG, exp_bit(d[0]));
    end
    wr(OFF_CONFIG, RST_ZERO);
    wr(OFF_IENSET, 32'h1);
    wr(OFF_IENCLR, 32'h0);
    rdc(OFF_IENCLR, exp_bit(1'b1));
    rdc(OFF_IENSET, exp_bit(1'b1));
    level <= 1'b1;
    wr(OFF_START, 32'h1);
    check(exp_bit(irq), exp_bit(1'b0));
    wait_irq(5000);
    check(exp_bit(running), exp_bit(1'b1));
    rdc(OFF_VALUE, exp_byte(1'b1));
    rdc(OFF_VALUE_READY, exp_bit(1'b1));
    level <= 1'b0;
    wr(OFF_VALUE_READY, 32'h0);
    repeat (2) @(posedge mclk);
    check(exp_bit(irq), exp_bit(1'b0));
    wait_irq(3800);
    rdc(OFF_VALUE, exp_byte(1'b0));
    wr(OFF_VALUE_READY, 32'h0);
    wr(OFF_IENCLR, 32'h1);
    rdc(OFF_IENSET, exp_bit(1'b0));
    repeat (3800) @(posedge mclk);
    rdc(OFF_VALUE_READY, exp_bit(1'b1));
    check(exp_bit(irq), exp_bit(1'b0));
    wr(OFF_STOP, 32'h1);
    wr(OFF_VALUE_READY, 32'h0);
    repeat (8000) @(posedge mclk);
    rdc(OFF_VALUE_READY, exp_bit(1'b0));
    check(exp_bit(running), exp_bit(1'b0));
    // Equal pairs yield nothing; random noise yields a byte.
    wr(OFF_CONFIG, 32'h1);
    wr(OFF_IENSET, 32'h1);
    level <= 1'b1;
    wr(OFF_START, 32'h1);
    repeat (16000) @(posedge mclk);
    check(exp_bit(irq), exp_bit(1'b0));
    use_rand <= 1'b1;
    wait_irq(60000);
    rdc(OFF_STATUS, 32'h3);
    wr(OFF_SHORTCUT, 32'h1);
    rdc(OFF_SHORTCUT, exp_bit(1'b1));
    wr(OFF_STOP, 32'h1);
    final_report();
  end

  // Watchdog: the run should finish long before this many cycles.
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    final_report();
  end
endmodule
